// [rtl/asp_consts.vh]
`ifndef ASP_CONSTS_VH
`define ASP_CONSTS_VH
`define ASP_OFS_PIN0 8'h00
`define ASP_OFS_GEN 8'h20
`define ASP_BIT_DROP 24
`define ASP_WID_HI 17
`define ASP_WID_LO 16
`define ASP_SPP_HI 15
`define ASP_SPP_LO 8
`define ASP_BIT_CAL 1
`define ASP_BIT_EN 0
`define ASP_PIN_BIT_EN 0
`define ASP_RST_DROP 1'b1
`define ASP_RST_WID 2'h1
`define ASP_RST_SPP 8'h01
`define ASP_WID_8 2'h0
`define ASP_WID_16 2'h1
`define ASP_WID_32 2'h3
`define ASP_CAL_PULSES 3'h6
`endif

// [rtl/asp_pin_mem.v]
`timescale 1ns/1ps
`include "asp_consts.vh"
// Per-pin control words, read data registered
module asp_pin_mem #(
  parameter NPINS = 4,
  parameter AW = 2
) (
  input wire core_clk,
  input wire srst,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [31:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [31:0] rd_data_ff,
  output wire [NPINS-1:0] pin_en,
  output wire [NPINS*24-1:0] pin_dest
);
  reg [31:0] word_ff [0:NPINS-1];
  genvar g;
  generate
    for (g = 0; g < NPINS; g = g + 1) begin : g_pin
      always @(posedge core_clk) begin
        if (srst) begin
          word_ff[g] <= 32'h0;
        end else if (wr_en && wr_addr == g) begin
          word_ff[g] <= {wr_data[31:8], 7'h00, wr_data[`ASP_PIN_BIT_EN]};
        end
      end
      assign pin_en[g] = word_ff[g][`ASP_PIN_BIT_EN];
      assign pin_dest[g*24 +: 24] = word_ff[g][31:8];
    end
  endgenerate

  always @(posedge core_clk) begin
    if (srst) begin
      rd_data_ff <= 32'h0;
    end else begin
      rd_data_ff <= word_ff[rd_addr];
    end
  end
endmodule // asp_pin_mem

// [rtl/asp_packetizer.v]
`timescale 1ns/1ps
`include "asp_consts.vh"
module asp_packetizer #(
  parameter NPINS = 4,
  parameter AW = 2
) (
  input wire core_clk,
  input wire srst,
  // Peripheral register port, 32-bit accesses
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata_ff,
  output reg reg_rvalid_ff,
  // Sampling clock pin, synchronous to core_clk
  input wire sample_clk_in,
  // Converter
  output reg conv_start_ff,
  output reg [AW-1:0] conv_pin_ff,
  output wire conv_cal_sel,
  output wire conv_enable,
  input wire conv_done,
  input wire [11:0] conv_result,
  // Outgoing byte stream to channel-end
  output reg [7:0] tx_data_ff,
  output reg [23:0] tx_dest_ff,
  output reg tx_end_ff,
  output wire tx_valid,
  input wire tx_ready
);
  ////////////////////////////////////////////////////////////////////////
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_CONV = 4'b0010;
  localparam [3:0] ST_SEND = 4'b0100;
  localparam [3:0] ST_CLOSE = 4'b1000;

  reg drop_ff;
  reg [1:0] wid_ff;
  reg [7:0] spp_ff;
  reg cal_ff;
  reg en_ff;
  reg smp_q_ff;
  reg [2:0] calcnt_ff;
  reg [3:0] st_ff;
  reg [AW-1:0] rot_ff;
  reg [31:0] shreg_ff;
  reg [2:0] bytes_left_ff;
  reg [7:0] pkt_cnt_ff;
  reg pkt_open_ff;
  reg [23:0] open_dest_ff;
  reg txv_ff;
  reg rd_gen_ff;
  reg rd_pin_ff;
  reg [31:0] gen_rd_ff;
  // Calibration status latched at start, since the counter steps on that same pulse
  reg conv_cal_ff;

  wire [NPINS-1:0] pin_en;
  wire [NPINS*24-1:0] pin_dest;
  wire [31:0] pin_rdata;

  wire is_gen = (reg_addr == `ASP_OFS_GEN);
  wire is_pin = (reg_addr[7:2] < NPINS) && (reg_addr[1:0] == 2'h0);
  wire acc = (reg_wr || reg_rd) && (is_gen || is_pin);
  wire pin_wr = reg_wr && is_pin && !en_ff;
  wire pulse = sample_clk_in && !smp_q_ff;
  wire cal_phase = (calcnt_ff != `ASP_CAL_PULSES);

  asp_pin_mem #(.NPINS(NPINS), .AW(AW)) u_mem (
    .core_clk(core_clk),
    .srst(srst),
    .wr_en(pin_wr),
    .wr_addr(reg_addr[AW+1:2]),
    .wr_data(reg_wdata),
    .rd_addr(reg_addr[AW+1:2]),
    .rd_data_ff(pin_rdata),
    .pin_en(pin_en),
    .pin_dest(pin_dest)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next enabled pin after rot_ff in rotation
  reg [AW-1:0] nxt_pin;
  reg nxt_found;
  integer i;
  integer j;
  always @* begin
    nxt_pin = rot_ff;
    nxt_found = 1'b0;
    j = 0;
    for (i = NPINS; i >= 1; i = i - 1) begin
      j = (rot_ff + i) % NPINS;
      if (pin_en[j]) begin
        nxt_pin = j[AW-1:0];
        nxt_found = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // General control register; set beats the read-clear
  wire drop_evt = pulse && en_ff && !cal_phase && (st_ff != ST_IDLE);
  always @(posedge core_clk) begin
    if (srst) begin
      drop_ff <= `ASP_RST_DROP;
      wid_ff <= `ASP_RST_WID;
      spp_ff <= `ASP_RST_SPP;
      cal_ff <= 1'b0;
      en_ff <= 1'b0;
    end else begin
      if (drop_evt) begin
        drop_ff <= 1'b1;
      end else if (reg_rd && is_gen) begin
        drop_ff <= 1'b0;
      end
      if (reg_wr && is_gen) begin
        wid_ff <= reg_wdata[`ASP_WID_HI:`ASP_WID_LO];
        spp_ff <= reg_wdata[`ASP_SPP_HI:`ASP_SPP_LO];
        cal_ff <= reg_wdata[`ASP_BIT_CAL];
        en_ff <= reg_wdata[`ASP_BIT_EN];
      end
    end
  end
  assign conv_cal_sel = cal_ff;
  assign conv_enable = en_ff;

  // Read data lags two cycles so the pin memory can register its output
  always @(posedge core_clk) begin
    if (srst) begin
      rd_gen_ff <= 1'b0;
      rd_pin_ff <= 1'b0;
      gen_rd_ff <= 32'h0;
      reg_rvalid_ff <= 1'b0;
      reg_rdata_ff <= 32'h0;
    end else begin
      rd_gen_ff <= reg_rd && is_gen;
      rd_pin_ff <= reg_rd && is_pin;
      gen_rd_ff <= {7'h00, drop_ff, 6'h00, wid_ff, spp_ff, 6'h00, cal_ff, en_ff};
      reg_rvalid_ff <= rd_gen_ff || rd_pin_ff;
      reg_rdata_ff <= rd_gen_ff ? gen_rd_ff : (rd_pin_ff ? pin_rdata : 32'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Calibration pulse counter, rearmed on each enable rise
  always @(posedge core_clk) begin
    if (srst) begin
      smp_q_ff <= 1'b0;
      calcnt_ff <= 3'h0;
    end else begin
      smp_q_ff <= sample_clk_in;
      if (!en_ff) begin
        calcnt_ff <= 3'h0;
      end else if (pulse && cal_phase) begin
        calcnt_ff <= calcnt_ff + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample state machine
  always @(posedge core_clk) begin
    if (srst) begin
      st_ff <= ST_IDLE;
      rot_ff <= {AW{1'b1}};
      conv_start_ff <= 1'b0;
      conv_pin_ff <= {AW{1'b0}};
      conv_cal_ff <= 1'b0;
      shreg_ff <= 32'h0;
      bytes_left_ff <= 3'h0;
      pkt_cnt_ff <= 8'h0;
      pkt_open_ff <= 1'b0;
      open_dest_ff <= 24'h0;
      txv_ff <= 1'b0;
      tx_data_ff <= 8'h0;
      tx_dest_ff <= 24'h0;
      tx_end_ff <= 1'b0;
    end else begin
      conv_start_ff <= 1'b0;
      case (st_ff)
        ST_IDLE: begin
          if (pkt_open_ff && ((acc && spp_ff == 8'h0) || !en_ff)) begin
            st_ff <= ST_CLOSE;
          end else if (pulse && en_ff && nxt_found) begin
            conv_start_ff <= 1'b1;
            conv_pin_ff <= nxt_pin;
            conv_cal_ff <= cal_phase;
            rot_ff <= nxt_pin;
            st_ff <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (pulse) begin
            st_ff <= ST_IDLE;
          end else if (conv_done) begin
            if (conv_cal_ff) begin
              st_ff <= ST_IDLE;
            end else begin
              // Packet cannot span two destinations
              if (pkt_open_ff && open_dest_ff != pin_dest[conv_pin_ff*24 +: 24]) begin
                pkt_cnt_ff <= 8'h0;
              end
              open_dest_ff <= pin_dest[conv_pin_ff*24 +: 24];
              pkt_open_ff <= 1'b1;
              if (wid_ff == `ASP_WID_8) begin
                shreg_ff <= {conv_result[11:4], 24'h0};
                bytes_left_ff <= 3'h1;
              end else if (wid_ff == `ASP_WID_32) begin
                shreg_ff <= {conv_result, 20'h0};
                bytes_left_ff <= 3'h4;
              end else begin
                shreg_ff <= {conv_result, 4'h0, 16'h0};
                bytes_left_ff <= 3'h2;
              end
              tx_dest_ff <= pin_dest[conv_pin_ff*24 +: 24];
              tx_end_ff <= 1'b0;
              st_ff <= ST_SEND;
            end
          end
        end
        ST_SEND: begin
          if (pulse && txv_ff && !tx_ready) begin
            txv_ff <= 1'b0;
            st_ff <= ST_IDLE;
          end else if (!txv_ff) begin
            tx_data_ff <= shreg_ff[31:24];
            shreg_ff <= {shreg_ff[23:0], 8'h00};
            txv_ff <= 1'b1;
          end else if (tx_ready) begin
            txv_ff <= 1'b0;
            bytes_left_ff <= bytes_left_ff - 3'h1;
            if (bytes_left_ff == 3'h1) begin
              pkt_cnt_ff <= pkt_cnt_ff + 8'h1;
              if (spp_ff != 8'h0 && pkt_cnt_ff + 8'h1 >= spp_ff) begin
                st_ff <= ST_CLOSE;
              end else begin
                st_ff <= ST_IDLE;
              end
            end
          end
        end
        ST_CLOSE: begin
          // End-of-packet marker, one handshake with tx_end high
          if (!txv_ff) begin
            tx_dest_ff <= open_dest_ff;
            tx_data_ff <= 8'h00;
            tx_end_ff <= 1'b1;
            txv_ff <= 1'b1;
          end else if (tx_ready) begin
            txv_ff <= 1'b0;
            tx_end_ff <= 1'b0;
            pkt_open_ff <= 1'b0;
            pkt_cnt_ff <= 8'h0;
            st_ff <= ST_IDLE;
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end
  assign tx_valid = txv_ff;
endmodule // asp_packetizer

// [test/asp_packetizer_chk.sv]
`timescale 1ns/1ps
module asp_chk (
  input logic core_clk,
  input logic srst,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_addr,
  input logic reg_rvalid_ff,
  input logic sample_clk_in,
  input logic conv_start_ff,
  input logic conv_cal_sel,
  input logic conv_enable,
  input logic [7:0] tx_data_ff,
  input logic [23:0] tx_dest_ff,
  input logic tx_end_ff,
  input logic tx_valid,
  input logic tx_ready
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_rd_ans; reg_rd && reg_addr == 8'h20 |-> ##2 reg_rvalid_ff; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("general read unanswered");
  property p_start_edge; conv_start_ff |-> $past(sample_clk_in) && !$past(sample_clk_in, 2); endproperty
  a_start_edge: assert property (p_start_edge) else $error("start without rising edge");
  property p_start_one; conv_start_ff |=> !conv_start_ff; endproperty
  a_start_one: assert property (p_start_one) else $error("start longer than a pulse");
  property p_start_en; conv_start_ff |-> $past(conv_enable); endproperty
  a_start_en: assert property (p_start_en) else $error("start while disabled");
  property p_cfg_hold; !$past(reg_wr) |-> $stable(conv_cal_sel) && $stable(conv_enable); endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("mode moved without write");
  property p_tx_hold;
    tx_valid && !tx_ready && !(sample_clk_in && !$past(sample_clk_in)) |=>
      tx_valid && $stable({tx_data_ff, tx_dest_ff, tx_end_ff});
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("byte changed before taken");
  property p_end_zero; tx_valid && tx_end_ff |-> tx_data_ff == 8'h00; endproperty
  a_end_zero: assert property (p_end_zero) else $error("end beat carries data");
  property p_gap; tx_valid && tx_ready |=> !tx_valid; endproperty
  a_gap: assert property (p_gap) else $error("no idle after byte");
  c_end: cover property (tx_valid && tx_ready && tx_end_ff);
  c_stall: cover property (tx_valid && !tx_ready ##1 tx_valid);
  c_conv: cover property (conv_start_ff);
endmodule // asp_chk
////////////////////////////////////////////////////////////////////////////////
bind asp_packetizer asp_chk u_asp_chk (.core_clk(core_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_rvalid_ff(reg_rvalid_ff), .sample_clk_in(sample_clk_in), .conv_start_ff(conv_start_ff),
  .conv_cal_sel(conv_cal_sel), .conv_enable(conv_enable), .tx_data_ff(tx_data_ff), .tx_dest_ff(tx_dest_ff),
  .tx_end_ff(tx_end_ff), .tx_valid(tx_valid), .tx_ready(tx_ready));

// [test/asp_sink.sv]
`timescale 1ns/1ps
module asp_sink (
  input logic core_clk,
  input logic hold,
  input logic tx_valid,
  input logic [7:0] tx_data_ff,
  input logic [23:0] tx_dest_ff,
  input logic tx_end_ff,
  output logic tx_ready
);
  logic [32:0] got [$];
  initial tx_ready = 1'b0;
  // Random stalls so the source must really hold each byte
  always @(negedge core_clk) tx_ready <= !hold && ($urandom_range(2) != 0);
  always @(posedge core_clk) if (tx_valid && tx_ready) got.push_back({tx_dest_ff, tx_end_ff, tx_data_ff});
endmodule // asp_sink

// [test/tb_asp_packetizer.sv]
`timescale 1ns/1ps
module tb_asp_packetizer;
  logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, sample_clk_in = 1'b0;
  logic conv_done = 1'b0, hold = 1'b0, tx_ready;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [11:0] conv_result = 12'h000, r;
  wire [31:0] reg_rdata_ff;
  wire reg_rvalid_ff, conv_start_ff, conv_cal_sel, conv_enable, tx_end_ff, tx_valid;
  wire [1:0] conv_pin_ff;
  wire [7:0] tx_data_ff;
  wire [23:0] tx_dest_ff;
  int err_total = 0, num_checks = 0, cd = 0, pulses = 0, ns = 0, np = 1, wid = 1, spp = 1;
  logic [23:0] dst [2] = '{24'h5a1c03, 24'h00e7b2};
  logic [32:0] exq [$];
  always #5 core_clk = ~core_clk;
  asp_packetizer u_asp_packetizer (.core_clk(core_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .sample_clk_in(sample_clk_in), .conv_start_ff(conv_start_ff), .conv_pin_ff(conv_pin_ff),
    .conv_cal_sel(conv_cal_sel), .conv_enable(conv_enable), .conv_done(conv_done), .conv_result(conv_result),
    .tx_data_ff(tx_data_ff), .tx_dest_ff(tx_dest_ff), .tx_end_ff(tx_end_ff), .tx_valid(tx_valid),
    .tx_ready(tx_ready));
  asp_sink u_asp_sink (.core_clk(core_clk), .hold(hold), .tx_valid(tx_valid), .tx_data_ff(tx_data_ff),
    .tx_dest_ff(tx_dest_ff), .tx_end_ff(tx_end_ff), .tx_ready(tx_ready));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [39:0] seen, input logic [39:0] want);
    num_checks++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge core_clk);
    reg_rd = 1'b0;
    for (int n = 0; n < 4 && reg_rvalid_ff !== 1'b1; n++) @(negedge core_clk);
    if (reg_rvalid_ff !== 1'b1) begin
      err_total++;
      tally_and_finish;
    end
    chk(reg_rdata_ff, want);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(negedge core_clk);
      sample_clk_in = 1'b1;
      @(negedge core_clk);
      sample_clk_in = 1'b0;
      repeat (40) @(negedge core_clk);
    end
  endtask
  // Reference stream: every sample left aligned in a 32-bit word, top bytes first
  task automatic push(input logic [11:0] v, input logic [23:0] d);
    logic [31:0] w;
    int nb;
    w = {v, 20'h0};
    nb = (wid == 0) ? 1 : (wid == 1) ? 2 : 4;
    for (int i = 0; i < nb; i++) exq.push_back({d, 1'b0, w[31-8*i -: 8]});
    ns++;
    if (spp != 0 && ns % spp == 0) exq.push_back({d, 1'b1, 8'h00});
  endtask
  task automatic drain;
    repeat (60) @(negedge core_clk);
    chk(u_asp_sink.got.size(), exq.size());
    foreach (exq[i]) chk(u_asp_sink.got[i], exq[i]);
    exq.delete();
    u_asp_sink.got.delete();
  endtask
  // Old width and count kept on disable so no empty packet is provoked
  task automatic round(input int w, input int s, input int n, input logic c);
    wr(8'h20, {14'h0, wid[1:0], spp[7:0], 8'h00});
    wid = w;
    spp = s;
    np = n;
    pulses = 0;
    ns = 0;
    wr(8'h00, {dst[0], 8'h01});
    wr(8'h04, {dst[1], 7'h0, n == 2});
    wr(8'h20, {14'h0, w[1:0], s[7:0], 6'h0, c, 1'b1});
    chk(conv_cal_sel, c);
    chk(conv_enable, 1'b1);
    pulse(6);
    chk(u_asp_sink.got.size(), 0);
    pulse(6);
    drain;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  always @(negedge core_clk) begin
    conv_done <= (cd == 1);
    if (cd != 0) cd <= cd - 1;
    if (conv_start_ff === 1'b1) begin
      r = 12'($urandom);
      conv_result <= r;
      cd <= 3;
      chk(conv_pin_ff, pulses % np);
      if (pulses >= 6) push(r, dst[pulses % np]);
      pulses++;
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(32'h47bf8648));
    repeat (5) @(negedge core_clk);
    srst = 1'b0;
    chk(conv_enable, 1'b0);
    rd(8'h20, 32'h0101_0100);
    rd(8'h20, 32'h0001_0100);
    round(0, 1, 2, 1'b0);
    round(1, 2, 1, 1'b1);
    wr(8'h00, 32'hffff_ff00);
    rd(8'h00, {dst[0], 8'h01});
    round(3, 0, 1, 1'b0);
    rd(8'h20, 32'h0003_0001);
    exq.push_back({dst[0], 1'b1, 8'h00});
    drain;
    hold = 1'b1;
    pulse(2);
    rd(8'h20, 32'h0103_0001);
    tally_and_finish;
  end
endmodule // tb_asp_packetizer
